/* imts_engine.sv */
// imts_engine: two-wire master transmitter and receiver with status codes and bus-error recovery
// assumes: open-drain pads outside, firmware drives the control and data write strobes
// Function
// R1: status output reads f8 whenever the interrupt flag is clear
// R2: bus error loads status 00 and sets the interrupt flag
// R3: start or stop seen inside a byte or acknowledge counts as bus error
// R4: software recovers from bus error by setting halt and clearing the flag
// R5: recovery enters not-addressed slave mode and clears halt only; here it returns to master idle, there is no slave mode
// R6: recovery releases both lines without sending a stop
// R7: software sets pad output latches high before enabling the interface
// R8: rate codes 000 to 011 divide the clock by 256, 224, 192, 160
// R9: rate code 110 divides by 60, 101 by 120, 100 unused
// R10: rate code 111 divides by 96 times (256 minus timer reload)
// R11: at 08 software loads address plus write, device sends it
// R12: at 10 address with read bit switches device to receive mode
// R13: at 18 to 30 data byte is sent, begin alone gives repeated start
// R14: halt alone sends stop then clears halt automatically
// R15: begin and halt together send stop, then start, clearing halt
// R16: at 38 release bus; with begin set, start once bus is free
// R17: transfer stays suspended while the interrupt flag is set
// R18: software sets interface enable before any operation
// R19: after reset status f8, flags clear, both lines released
`timescale 1ns/10ps
module imts_engine
    import imts_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RESETN,
    // control register write
    input wire logic CTRL_WR,
    input wire logic [7:0] CTRL_WDATA,
    // data register write
    input wire logic DATA_WR,
    input wire logic [7:0] DATA_WDATA,
    // timer reload for rate code 111
    input wire logic [7:0] TIMER_RELOAD,
    // register views
    output logic [7:0] CTRL_Q,
    output logic [7:0] DATA_Q,
    output logic [7:0] CODE_Q,
    // serial clock pad
    input wire logic SCL_IN,
    output logic SCL_OUT,
    output logic SCL_OE,
    // serial data pad
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    imts_state_t state;
    logic [2:0] rate_sel;
    logic iface_enable, begin_request, halt_request, irq_flag, ack_enable;
    logic [7:0] shift_data_reg, code_reg, shift;
    logic [1:0] quarter;
    logic [3:0] bit_cnt;
    logic scl_m, scl_s, sda_m, sda_s, sda_d;
    logic bus_busy, own_bus, rx_mode, addr_phase, ack_cap;
    logic scl_drv, sda_drv, irq_set, halt_clr;
    logic tick;

    ////////////////////////////////////////////////////////////////////////////
    // decode

    // bus condition detection on synchronised lines
    wire start_seen = sda_d & ~sda_s & scl_s;
    wire stop_seen = ~sda_d & sda_s & scl_s;
    wire wr_begin = CTRL_WDATA[CTRL_BEGIN];
    wire wr_halt = CTRL_WDATA[CTRL_HALT];
    // R17 resume only when software clears the flag
    wire resume = CTRL_WR & ~CTRL_WDATA[CTRL_IRQ] & irq_flag;
    wire run_div = (state == IMTS_START) | (state == IMTS_BYTE) | (state == IMTS_STOP);
    wire last_bit = (bit_cnt == 4'h8);
    // value this bit drives low
    wire drive_low = last_bit ? (rx_mode & ack_cap) : (~rx_mode & ~shift[7]);
    wire arb_lost = ~rx_mode & ~last_bit & shift[7] & ~sda_s;
    wire stall = (quarter == 2'h2) & ~scl_s; // slave clock stretching
    wire tx_code = (code_reg == CODE_START) | (code_reg == CODE_RESTART) |
                   (code_reg == CODE_ADDR_W_ACK) | (code_reg == CODE_ADDR_W_NACK) |
                   (code_reg == CODE_DATA_TX_ACK) | (code_reg == CODE_DATA_TX_NACK);
    wire rx_code = (code_reg == CODE_ADDR_R_ACK) | (code_reg == CODE_DATA_RX_ACK);
    wire addr_code = (code_reg == CODE_START) | (code_reg == CODE_RESTART);
    wire [7:0] addr_done_code = shift[0] ? (sda_s ? CODE_ADDR_R_NACK : CODE_ADDR_R_ACK)
                                        : (sda_s ? CODE_ADDR_W_NACK : CODE_ADDR_W_ACK);
    wire [7:0] tx_done_code = sda_s ? CODE_DATA_TX_NACK : CODE_DATA_TX_ACK;
    wire [7:0] rx_done_code = ack_cap ? CODE_DATA_RX_ACK : CODE_DATA_RX_NACK;
    wire [7:0] byte_done_code = addr_phase ? addr_done_code :
                                rx_mode ? rx_done_code : tx_done_code;

    ////////////////////////////////////////////////////////////////////////////
    // rate divider

    // R8 R9 R10 bit rate from rate code
    imts_rate_div u_rate (
        .clock(CLOCK),
        .resetn(RESETN),
        .run(run_div),
        .rate_sel(rate_sel),
        .reload(TIMER_RELOAD),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // pad inputs

    // two-stage synchronisers, plus one delay stage for edges
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_m <= SCL_IN;
            scl_s <= scl_m;
            sda_m <= SDA_IN;
            sda_s <= sda_m;
            sda_d <= sda_s;
        end
    end

    // bus busy between any start and stop
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            bus_busy <= 1'b0;
        end else if (start_seen) begin
            bus_busy <= 1'b1;
        end else if (stop_seen) begin
            bus_busy <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control and data registers

    // R19 flags clear at reset
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            {rate_sel[2], iface_enable, begin_request, halt_request} <= CTRL_RESET[7:4];
            {irq_flag, ack_enable, rate_sel[1:0]} <= CTRL_RESET[3:0];
        end else begin
            if (CTRL_WR) begin
                rate_sel <= {CTRL_WDATA[CTRL_RATE2], CTRL_WDATA[CTRL_RATE1:CTRL_RATE0]};
                iface_enable <= CTRL_WDATA[CTRL_ENABLE];
                begin_request <= wr_begin;
                ack_enable <= CTRL_WDATA[CTRL_ACK];
            end
            // R14 hardware clear of halt wins
            halt_request <= (CTRL_WR ? wr_halt : halt_request) & ~halt_clr;
            // hardware set wins over software clear
            irq_flag <= irq_set | (irq_flag & ~resume);
        end
    end

    // data register, received bytes land here
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            shift_data_reg <= DATA_RESET;
        end else if (state == IMTS_BYTE && tick && quarter == 2'h3 && last_bit && rx_mode) begin
            shift_data_reg <= shift;
        end else if (DATA_WR) begin
            shift_data_reg <= DATA_WDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            state <= IMTS_IDLE;
            code_reg <= CODE_NO_INFO;
            quarter <= 2'h0;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            own_bus <= 1'b0;
            rx_mode <= 1'b0;
            addr_phase <= 1'b0;
            ack_cap <= 1'b0;
            scl_drv <= 1'b0;
            sda_drv <= 1'b0;
            irq_set <= 1'b0;
            halt_clr <= 1'b0;
        end else begin
            irq_set <= 1'b0;
            halt_clr <= 1'b0;
            if (!iface_enable) begin
                state <= IMTS_IDLE;
                own_bus <= 1'b0;
                scl_drv <= 1'b0;
                sda_drv <= 1'b0;
            end else if (state == IMTS_BYTE && (start_seen || stop_seen)) begin
                // R3 illegal start or stop inside a byte
                // R2 report bus error
                state <= IMTS_ERROR;
                code_reg <= CODE_BUS_ERROR;
                irq_set <= 1'b1;
                own_bus <= 1'b0;
                scl_drv <= 1'b0;
                sda_drv <= 1'b0;
            end else begin
                case (state)
                    IMTS_IDLE: begin
                        // R16 start waits for a free bus
                        if (begin_request && !bus_busy && !irq_flag) begin
                            state <= IMTS_START;
                            quarter <= 2'h0;
                        end
                    end
                    IMTS_START: begin
                        if (tick && !stall) begin
                            quarter <= quarter + 2'h1;
                            case (quarter)
                                2'h0: sda_drv <= 1'b0;
                                2'h1: scl_drv <= 1'b0;
                                2'h2: sda_drv <= 1'b1;
                                default: begin
                                    scl_drv <= 1'b1;
                                    code_reg <= own_bus ? CODE_RESTART : CODE_START;
                                    own_bus <= 1'b1;
                                    rx_mode <= 1'b0;
                                    irq_set <= 1'b1;
                                    state <= IMTS_HOLD;
                                end
                            endcase
                        end
                    end
                    IMTS_HOLD: begin
                        // R17 wait for the flag to be cleared
                        if (resume) begin
                            quarter <= 2'h0;
                            bit_cnt <= 4'h0;
                            if (!own_bus) begin
                                // R16 arbitration lost, begin retried from idle
                                state <= IMTS_IDLE;
                            end else if (wr_halt) begin
                                // R14 R15 stop first, start follows if begin set
                                state <= IMTS_STOP;
                            end else if (wr_begin) begin
                                // R13 repeated start
                                state <= IMTS_START;
                            end else if (tx_code || rx_code) begin
                                // R11 R13 send the loaded byte; at 40 or 50 receive a byte instead
                                state <= IMTS_BYTE;
                                addr_phase <= addr_code;
                                shift <= rx_code ? 8'hff : shift_data_reg;
                                ack_cap <= CTRL_WDATA[CTRL_ACK];
                            end
                        end
                    end
                    IMTS_BYTE: begin
                        if (tick && !stall) begin
                            quarter <= quarter + 2'h1;
                            case (quarter)
                                2'h0: sda_drv <= drive_low;
                                2'h1: scl_drv <= 1'b0;
                                2'h2: begin
                                    if (arb_lost) begin
                                        // R16 lost: release at once, report 38
                                        code_reg <= CODE_ARB_LOST;
                                        own_bus <= 1'b0;
                                        irq_set <= 1'b1;
                                        state <= IMTS_HOLD;
                                    end else if (!last_bit) begin
                                        shift <= {shift[6:0], sda_s};
                                    end
                                end
                                default: begin
                                    scl_drv <= 1'b1;
                                    bit_cnt <= bit_cnt + 4'h1;
                                    if (last_bit) begin
                                        // R12 read bit selects receive mode
                                        if (addr_phase) begin
                                            rx_mode <= shift[0];
                                        end
                                        code_reg <= byte_done_code;
                                        addr_phase <= 1'b0;
                                        sda_drv <= 1'b0;
                                        irq_set <= 1'b1;
                                        state <= IMTS_HOLD;
                                    end
                                end
                            endcase
                        end
                    end
                    IMTS_STOP: begin
                        if (tick && !stall) begin
                            quarter <= quarter + 2'h1;
                            case (quarter)
                                2'h0: sda_drv <= 1'b1;
                                2'h1: scl_drv <= 1'b0;
                                2'h2: sda_drv <= 1'b0;
                                default: begin
                                    // R14 R15 clear halt after the stop
                                    halt_clr <= 1'b1;
                                    own_bus <= 1'b0;
                                    state <= IMTS_IDLE;
                                end
                            endcase
                        end
                    end
                    IMTS_ERROR: begin
                        // R5 R6 recover: release lines, no stop, clear halt only
                        if (resume && wr_halt) begin
                            halt_clr <= 1'b1;
                            scl_drv <= 1'b0;
                            sda_drv <= 1'b0;
                            state <= IMTS_IDLE;
                        end
                    end
                    default: state <= IMTS_IDLE;
                endcase
                if (state == IMTS_BYTE && tick && !stall && quarter == 2'h2 && arb_lost) begin
                    scl_drv <= 1'b0;
                    sda_drv <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs

    // R1 f8 whenever the flag is clear
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            CODE_Q <= CODE_NO_INFO;
            CTRL_Q <= CTRL_RESET;
            DATA_Q <= DATA_RESET;
            SCL_OE <= 1'b0;
            SDA_OE <= 1'b0;
            SCL_OUT <= 1'b0;
            SDA_OUT <= 1'b0;
        end else begin
            CODE_Q <= irq_flag ? code_reg : CODE_NO_INFO;
            CTRL_Q <= {rate_sel[2], iface_enable, begin_request, halt_request,
                       irq_flag, ack_enable, rate_sel[1:0]};
            DATA_Q <= shift_data_reg;
            SCL_OE <= scl_drv;
            SDA_OE <= sda_drv;
            SCL_OUT <= 1'b0;
            SDA_OUT <= 1'b0;
        end
    end

endmodule // imts_engine

/* imts_pkg.sv */
// imts_pkg: constants shared by the two-wire master status engine
// assumes: 40 MHz core clock, firmware-side control bits reach the block as plain ports
package imts_pkg;

    // control word bit positions
    localparam int CTRL_RATE2 = 7;
    localparam int CTRL_ENABLE = 6;
    localparam int CTRL_BEGIN = 5;
    localparam int CTRL_HALT = 4;
    localparam int CTRL_IRQ = 3;
    localparam int CTRL_ACK = 2;
    localparam int CTRL_RATE1 = 1;
    localparam int CTRL_RATE0 = 0;

    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // status codes
    localparam logic [7:0] CODE_NO_INFO = 8'hf8;
    localparam logic [7:0] CODE_BUS_ERROR = 8'h00;
    localparam logic [7:0] CODE_START = 8'h08;
    localparam logic [7:0] CODE_RESTART = 8'h10;
    localparam logic [7:0] CODE_ADDR_W_ACK = 8'h18;
    localparam logic [7:0] CODE_ADDR_W_NACK = 8'h20;
    localparam logic [7:0] CODE_DATA_TX_ACK = 8'h28;
    localparam logic [7:0] CODE_DATA_TX_NACK = 8'h30;
    localparam logic [7:0] CODE_ARB_LOST = 8'h38;
    localparam logic [7:0] CODE_ADDR_R_ACK = 8'h40;
    localparam logic [7:0] CODE_ADDR_R_NACK = 8'h48;
    localparam logic [7:0] CODE_DATA_RX_ACK = 8'h50;
    localparam logic [7:0] CODE_DATA_RX_NACK = 8'h58;

    // bit period divisors of the peripheral clock, per rate code
    localparam int DIV_SEL0 = 256;
    localparam int DIV_SEL1 = 224;
    localparam int DIV_SEL2 = 192;
    localparam int DIV_SEL3 = 160;
    localparam int DIV_SEL5 = 120;
    localparam int DIV_SEL6 = 60;
    localparam int DIV_TIMER = 96;
    localparam int QUARTERS = 4;

    // quarter-bit lengths in clock cycles
    localparam logic [12:0] QLEN_SEL0 = 13'(DIV_SEL0 / QUARTERS);
    localparam logic [12:0] QLEN_SEL1 = 13'(DIV_SEL1 / QUARTERS);
    localparam logic [12:0] QLEN_SEL2 = 13'(DIV_SEL2 / QUARTERS);
    localparam logic [12:0] QLEN_SEL3 = 13'(DIV_SEL3 / QUARTERS);
    localparam logic [12:0] QLEN_SEL5 = 13'(DIV_SEL5 / QUARTERS);
    localparam logic [12:0] QLEN_SEL6 = 13'(DIV_SEL6 / QUARTERS);
    localparam logic [4:0] QLEN_TIMER_MUL = 5'(DIV_TIMER / QUARTERS);

    // sequencer states
    typedef enum logic [5:0] {
        IMTS_IDLE = 6'h01,
        IMTS_START = 6'h02,
        IMTS_BYTE = 6'h04,
        IMTS_HOLD = 6'h08,
        IMTS_STOP = 6'h10,
        IMTS_ERROR = 6'h20
    } imts_state_t;

endpackage

/* imts_rate_div.sv */
// imts_rate_div: quarter-bit tick generator for the serial clock
// assumes: run is low between bus phases so each phase starts a full quarter
`timescale 1ns/10ps
module imts_rate_div
    import imts_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // control
    input wire logic run,
    input wire logic [2:0] rate_sel,
    input wire logic [7:0] reload,
    // tick out
    output logic tick
);

    logic [12:0] count;
    logic [8:0] span;
    logic [12:0] timer_qlen;
    logic [12:0] qlen;
    logic at_end;

    // timer based rate: 24 * (256 - reload) cycles per quarter
    assign span = 9'h100 - {1'b0, reload};
    assign timer_qlen = 13'({4'h0, span} * {8'h00, QLEN_TIMER_MUL});

    // quarter length per rate code, unused code falls back to code 000 (divide by 256)
    assign qlen = (rate_sel == 3'h1) ? QLEN_SEL1 :
                  (rate_sel == 3'h2) ? QLEN_SEL2 :
                  (rate_sel == 3'h3) ? QLEN_SEL3 :
                  (rate_sel == 3'h5) ? QLEN_SEL5 :
                  (rate_sel == 3'h6) ? QLEN_SEL6 :
                  (rate_sel == 3'h7) ? timer_qlen : QLEN_SEL0;
    assign at_end = (count >= qlen - 13'h0001);

    // free count while running, one pulse per quarter
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count <= 13'h0000;
            tick <= 1'b0;
        end else begin
            tick <= run & at_end;
            count <= (!run || at_end) ? 13'h0000 : count + 13'h0001;
        end
    end

endmodule // imts_rate_div

/* imts_slave_model.sv */
// imts_slave_model: behavioural slave on the two-wire bus
// assumes: pulled-up open-drain lines resolved by the bench
`timescale 1ns/10ps
module imts_slave_model (
    // bus levels
    input wire logic scl,
    input wire logic sda,
    // behaviour select
    input wire logic ack_en,
    input wire logic err_mode,
    // pull-down and stop tally
    output logic sda_oe,
    output int stop_cnt
);
    int bit_cnt = 0;
    initial begin
        sda_oe = 1'b0;
        stop_cnt = 0;
    end
    // start restarts the bit count, stops are tallied
    always @(negedge sda) if (scl) bit_cnt = 0;
    always @(posedge sda) if (scl) stop_cnt++;
    always @(posedge scl) begin
        bit_cnt++;
        if (bit_cnt == 9 && err_mode && sda_oe) begin
            #125;
            sda_oe = 1'b0;
        end
    end
    // ack slot after the eighth falling clock
    always @(negedge scl) begin
        sda_oe <= (bit_cnt == 8) && ack_en;
        if (bit_cnt >= 9) bit_cnt = 0;
    end
endmodule // imts_slave_model

/* imts_sva.sv */
// imts_sva: port-level checks for the two-wire master status engine
// assumes: bound to imts_engine, one clock domain
`timescale 1ns/10ps
module imts_sva
    import imts_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RESETN,
    // control and status views
    input wire logic CTRL_WR,
    input wire logic [7:0] CTRL_Q,
    input wire logic [7:0] CODE_Q,
    // pads
    input wire logic SCL_OUT,
    input wire logic SCL_OE,
    input wire logic SDA_OUT,
    input wire logic SDA_OE
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    ////////////////////////////////////////////////////////////////////////////////
    // bus owned and waiting for firmware
    logic owned;
    assign owned = CTRL_Q[CTRL_IRQ] && (CODE_Q inside {CODE_START, CODE_RESTART,
        CODE_ADDR_W_ACK, CODE_ADDR_W_NACK, CODE_DATA_TX_ACK, CODE_DATA_TX_NACK, CODE_ADDR_R_ACK});
    ////////////////////////////////////////////////////////////////////////////////
    chk_code_noinfo: assert property (
        !CTRL_Q[CTRL_IRQ] && !$past(CTRL_Q[CTRL_IRQ]) |-> CODE_Q == CODE_NO_INFO)
        else $error("status not f8 while flag clear");
    chk_flag_code: assert property (
        $rose(CTRL_Q[CTRL_IRQ]) |-> ##[0:2] CODE_Q != CODE_NO_INFO)
        else $error("flag set without a status code");
    chk_err_flag: assert property (
        $rose(CODE_Q == CODE_BUS_ERROR) |-> ##[0:1] CTRL_Q[CTRL_IRQ])
        else $error("bus error code without flag");
    chk_err_release: assert property (
        (CODE_Q == CODE_BUS_ERROR) [*3] |-> !SCL_OE && !SDA_OE)
        else $error("lines held during bus error");
    chk_halt_only: assert property (
        $fell(CTRL_Q[CTRL_HALT]) && !$past(CTRL_WR, 2) |-> (CTRL_Q ^ $past(CTRL_Q)) == 8'h10)
        else $error("hardware halt clear touched other bits");
    chk_susp_hold: assert property (
        owned [*3] |-> SCL_OE && $stable(SDA_OE))
        else $error("bus moved while suspended");
    chk_reset_idle: assert property (
        $rose(RESETN) |-> CODE_Q == CODE_NO_INFO && CTRL_Q == 8'h00 && !SCL_OE && !SDA_OE)
        else $error("wrong state after reset");
    chk_pads_odrain: assert property (
        SCL_OUT == 1'b0 && SDA_OUT == 1'b0)
        else $error("pad driven high");
    chk_off_release: assert property (
        (!CTRL_Q[CTRL_ENABLE]) [*3] |-> !SCL_OE && !SDA_OE)
        else $error("lines held while disabled");
    // main scenarios reached
    cov_bus_error: cover property (CODE_Q == CODE_BUS_ERROR);
    cov_read_addr: cover property (CODE_Q == CODE_ADDR_R_ACK);
    cov_halt_clear: cover property ($fell(CTRL_Q[CTRL_HALT]));
endmodule // imts_sva

bind imts_engine imts_sva imts_sva_inst (.CLOCK(CLOCK), .RESETN(RESETN), .CTRL_WR(CTRL_WR),
    .CTRL_Q(CTRL_Q), .CODE_Q(CODE_Q), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE),
    .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE));

/* tb_top.sv */
// tb_top: self-checking bench for the two-wire master status engine
// assumes: one slave model on the bus, pull-ups on both lines
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top
    import imts_pkg::*;
;
    typedef struct {logic [7:0] c; logic [7:0] d; logic wd; logic ack; logic [7:0] exp;} imts_row_t;
    logic clock, resetn, ctrl_wr, data_wr, ack_en, err_mode;
    logic [7:0] ctrl_wdata, data_wdata, timer_reload, ctrl_q, data_q, code_q;
    logic scl_out, scl_oe, sda_out, sda_oe, slave_oe;
    wire scl, sda;
    int stop_cnt, failures, num_checks, s;
    imts_row_t rows [10] = '{'{8'he2, 8'h00, 0, 1, 8'h08}, '{8'hc2, 8'ha0, 1, 1, 8'h18},
        '{8'hc2, 8'h55, 1, 0, 8'h30}, '{8'hc1, 8'h33, 1, 1, 8'h28}, '{8'he1, 8'h00, 0, 1, 8'h10},
        '{8'h43, 8'ha0, 1, 0, 8'h20}, '{8'h41, 8'h12, 1, 1, 8'h28}, '{8'h42, 8'h34, 1, 1, 8'h28},
        '{8'h60, 8'h00, 0, 1, 8'h10}, '{8'hc3, 8'ha1, 1, 1, 8'h40}};
    // open-drain lines pulled up, idle high before enable
    assign scl = !scl_oe;
    assign sda = !(sda_oe || slave_oe);
    imts_engine imts_engine_inst (.CLOCK(clock), .RESETN(resetn), .CTRL_WR(ctrl_wr),
        .CTRL_WDATA(ctrl_wdata), .DATA_WR(data_wr), .DATA_WDATA(data_wdata),
        .TIMER_RELOAD(timer_reload), .CTRL_Q(ctrl_q), .DATA_Q(data_q), .CODE_Q(code_q),
        .SCL_IN(scl), .SCL_OUT(scl_out), .SCL_OE(scl_oe), .SDA_IN(sda), .SDA_OUT(sda_out),
        .SDA_OE(sda_oe));
    imts_slave_model imts_slave_model_inst (.scl(scl), .sda(sda), .ack_en(ack_en),
        .err_mode(err_mode), .sda_oe(slave_oe), .stop_cnt(stop_cnt));
    ////////////////////////////////////////////////////////////////////////////////
    // optional data load, then control write
    task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic wd);
        if (wd) begin
            data_wdata <= d;
            data_wr <= 1'b1;
            @(posedge clock);
            data_wr <= 1'b0;
        end
        ctrl_wdata <= c;
        ctrl_wr <= 1'b1;
        @(posedge clock);
        ctrl_wr <= 1'b0;
        repeat (3) @(posedge clock);
    endtask
    // bounded wait for a status code or for halt to drop
    task automatic wait_for(input logic halt);
        int n;
        n = 0;
        while ((halt ? ctrl_q[CTRL_HALT] === 1'b1 : code_q === CODE_NO_INFO) && n < 20000) begin
            @(posedge clock);
            n++;
        end
        if (n == 20000) begin
            failures++;
            $display("[FAIL] t=%0t wait ran out code=%h ctrl=%h", $time, code_q, ctrl_q);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #12.5 clock = !clock;
    end
    // watchdog
    initial begin
        repeat (60000) @(posedge clock);
        failures++;
        stop_test();
    end
    initial begin
        resetn = 1'b0;
        ctrl_wr = 1'b0;
        data_wr = 1'b0;
        ctrl_wdata = 8'h00;
        data_wdata = 8'h00;
        timer_reload = 8'hfa;
        ack_en = 1'b1;
        err_mode = 1'b0;
        failures = 0;
        num_checks = 0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        `CHK({code_q, ctrl_q, scl_oe, sda_oe}, {CODE_NO_INFO, 8'h00, 2'b00});
        // ordinary transfers across rate codes
        foreach (rows[i]) begin
            ack_en <= rows[i].ack;
            wr(rows[i].c, rows[i].d, rows[i].wd);
            wait_for(1'b0);
            `CHK(code_q, rows[i].exp);
            $display("row %0d done", i);
        end
        `CHK(data_q, 8'ha1);
        // halt alone: stop, halt self-clears
        s = stop_cnt;
        wr(8'hd2, 8'h00, 1'b0);
        wait_for(1'b1);
        repeat (2) @(posedge clock);
        `CHK({ctrl_q, code_q, scl_oe, sda_oe}, {8'hc2, CODE_NO_INFO, 2'b00});
        `CHK(stop_cnt, s + 1);
        $display("stop test done");
        // begin with halt: stop then start
        ack_en <= 1'b1;
        wr(8'he2, 8'h00, 1'b0);
        wait_for(1'b0);
        wr(8'hc2, 8'ha0, 1'b1);
        wait_for(1'b0);
        s = stop_cnt;
        wr(8'hf2, 8'h00, 1'b0);
        wait_for(1'b0);
        `CHK({code_q, ctrl_q[CTRL_HALT]}, {CODE_START, 1'b0});
        `CHK(stop_cnt, s + 1);
        $display("stop-start test done");
        // stop inside the ack bit, then recovery
        err_mode <= 1'b1;
        wr(8'hc2, 8'ha0, 1'b1);
        wait_for(1'b0);
        repeat (3) @(posedge clock);
        `CHK({code_q, scl_oe, sda_oe}, {CODE_BUS_ERROR, 2'b00});
        err_mode <= 1'b0;
        s = stop_cnt;
        wr(8'hd2, 8'h00, 1'b0);
        wait_for(1'b1);
        repeat (2) @(posedge clock);
        `CHK({ctrl_q, code_q, scl_oe, sda_oe}, {8'hc2, CODE_NO_INFO, 2'b00});
        `CHK(stop_cnt, s);
        $display("bus error test done");
        // reset in mid-run
        wr(8'he2, 8'h00, 1'b0);
        resetn <= 1'b0;
        repeat (2) @(posedge clock);
        `CHK({code_q, ctrl_q, scl_oe, sda_oe}, {CODE_NO_INFO, 8'h00, 2'b00});
        resetn <= 1'b1;
        repeat (2) @(posedge clock);
        `CHK({code_q, ctrl_q, scl_oe, sda_oe}, {CODE_NO_INFO, 8'h00, 2'b00});
        $display("reset test done");
        stop_test();
    end
endmodule // tb_top
